//--- core/hpwm_pkg.sv
// Package for the heating PWM cycle block: timing and width constants.
// Assumes a single 100 MHz core clock.
`default_nettype none
package hpwm_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  // Timebase tick of one millisecond drives the period counter
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  // Switching period in minutes, and in timebase ticks
  localparam int unsigned PERIOD_MIN = 10;
  localparam int unsigned PERIOD_TICKS = PERIOD_MIN * 60 * 1000 / TICK_MS;
  localparam int unsigned PCT_W = 7;
  localparam logic [PCT_W-1:0] PCT_FULL = 7'h64;
  localparam int unsigned CNT_W = 32;
endpackage : hpwm_pkg
`default_nettype wire

//--- core/hpwm_cycle.sv
// Heating PWM cycle: percentage control variable to on/off actuator output.
// Assumes the control variable arrives synchronously on core_clk with a strobe.
`default_nettype none
module hpwm_cycle
  import hpwm_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned PERIOD = PERIOD_TICKS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Control variable from the room controller
  input wire logic [PCT_W-1:0] ctrlPct,
  input wire logic ctrlValid,
  // Actuator drive
  output logic actuatorOn,
  output logic periodStart
);

  // One bit flips between ON and OFF, the usual path
  typedef enum logic [1:0] {HPWM_ON = 2'b00, HPWM_OFF = 2'b01, HPWM_HOLD = 2'b11} hpwm_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Timebase divider
  // Restarts on reset so that ticks line up with the period
  logic [CNT_W-1:0] divCnt;
  logic tick;
  assign tick = (divCnt == CNT_W'(TICK_DIV - 1));

  always_ff @(posedge core_clk) begin
    if (!resetn || tick) begin
      divCnt <= '0;
    end else begin
      divCnt <= divCnt + CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Period position and served on-time
  logic [CNT_W-1:0] phase;
  logic [CNT_W-1:0] served;
  logic wrap;
  assign wrap = tick && (phase == CNT_W'(PERIOD - 1));

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      phase <= '0;
      periodStart <= 1'b0;
    end else begin
      periodStart <= wrap;
      if (wrap) begin
        phase <= '0;
      end else if (tick) begin
        phase <= phase + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn || wrap) begin
      served <= '0;
    end else if (tick && actuatorOn) begin
      served <= served + CNT_W'(1);
    end
  end

  // Served count as it will stand after this edge; deciding on it ends
  // the on-time exactly at the tick that reaches the target
  logic [CNT_W-1:0] servedNow;
  assign servedNow = served + CNT_W'(tick && actuatorOn);

  ////////////////////////////////////////////////////////////////////////////
  // Target on-time, taken at once from each new value
  logic [PCT_W-1:0] pct;
  logic [CNT_W-1:0] target;

  function automatic logic [CNT_W-1:0] pctToTicks(input logic [PCT_W-1:0] p);
    logic [63:0] prod;
    // Floor: any fraction of a tick is dropped
    prod = 64'(p) * 64'(PERIOD) / 64'(PCT_FULL);
    return prod[CNT_W-1:0];
  endfunction

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pct <= '0;
    end else if (ctrlValid) begin
      // Values above full scale clamp rather than wrap
      pct <= (ctrlPct > PCT_FULL) ? PCT_FULL : ctrlPct;
    end
  end
  assign target = pctToTicks(pct);

  ////////////////////////////////////////////////////////////////////////////
  // Output state: HOLD keeps off until next period after an overrun
  hpwm_state_t state;
  hpwm_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      HPWM_ON, HPWM_OFF: begin
        if (servedNow > target) begin
          next_state = HPWM_HOLD;
        end else if (servedNow < target) begin
          next_state = HPWM_ON;
        end else begin
          next_state = HPWM_OFF;
        end
      end
      HPWM_HOLD: next_state = HPWM_HOLD;
      default: next_state = HPWM_OFF;
    endcase
    if (wrap) begin
      // New period restarts from the current target
      // HOLD is left only here
      next_state = (target != '0) ? HPWM_ON : HPWM_OFF;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state <= HPWM_OFF;
    end else begin
      state <= next_state;
    end
  end
  assign actuatorOn = (state == HPWM_ON);

  ////////////////////////////////////////////////////////////////////////////
  // Check helper: on-cycles of a period with no new control variable
  // Wide so the ten-minute default cannot overflow it
  logic [63:0] onCycles;
  logic quietPeriod;

  always_ff @(posedge core_clk) begin
    if (!resetn || wrap) begin
      onCycles <= '0;
    end else begin
      onCycles <= onCycles + 64'(actuatorOn);
    end
  end

  // A new value at the wrap edge spoils the period that starts there
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      quietPeriod <= 1'b0;
    end else if (wrap) begin
      quietPeriod <= !ctrlValid;
    end else if (ctrlValid) begin
      quietPeriod <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_on_below_target: assert property (
    (servedNow < target) && !wrap && (state != HPWM_HOLD) |=> actuatorOn)
    else $error("output off while below target");
  chk_off_at_target: assert property (
    (servedNow == target) && !wrap && (state != HPWM_HOLD) |=> !actuatorOn)
    else $error("output on after target reached");
  chk_overrun_hold: assert property (
    (servedNow > target) && !wrap |=> !actuatorOn && (state == HPWM_HOLD))
    else $error("overrun did not turn output off");
  chk_hold_to_wrap: assert property (
    (state == HPWM_HOLD) && !wrap |=> (state == HPWM_HOLD))
    else $error("hold left before period end");
  chk_zero_off: assert property (
    (pct == '0) && $stable(pct) && !$rose(resetn) |=> !actuatorOn)
    else $error("output on at zero percent");
  chk_served_bound: assert property (
    served <= phase + CNT_W'(1))
    else $error("served exceeds elapsed period");
  chk_phase_wrap: assert property (
    wrap |=> (phase == '0) && periodStart)
    else $error("period did not restart");
  chk_new_value: assert property (
    ctrlValid && (ctrlPct <= PCT_FULL) |=> (pct == $past(ctrlPct)))
    else $error("new control variable not applied");

  // Steady-period duty and corner cases
  chk_period_duty: assert property (
    wrap && quietPeriod |-> (onCycles + 64'(actuatorOn)) == 64'(target) * 64'(TICK_DIV))
    else $error("on-time of a steady period wrong");
  chk_full_on: assert property (
    (pct == PCT_FULL) && !wrap && (state != HPWM_HOLD) |=> actuatorOn)
    else $error("output off at full scale");
  chk_reset_quiet: assert property (
    $rose(resetn) |-> !actuatorOn && !periodStart && (phase == '0) && (served == '0))
    else $error("state not cleared by reset");
  chk_clamp_full: assert property (
    ctrlValid && (ctrlPct > PCT_FULL) |=> (pct == PCT_FULL))
    else $error("over-range value not clamped");
  chk_served_idle: assert property (
    !actuatorOn && !wrap |=> $stable(served))
    else $error("served counted while off");
  chk_wrap_restart: assert property (
    wrap |=> (actuatorOn == ($past(target) != '0)))
    else $error("period start did not apply target");

  cov_increase: cover property (ctrlValid && (ctrlPct > pct) && !actuatorOn);
  cov_decrease: cover property (ctrlValid && (ctrlPct < pct) && actuatorOn);
  cov_hold: cover property (state == HPWM_HOLD);
  cov_wrap_on: cover property (wrap && actuatorOn);
  cov_full_steady: cover property (wrap && quietPeriod && (pct == PCT_FULL));

endmodule // hpwm_cycle
`default_nettype wire

//--- testbench/hpwm_valve.sv
// Valve actuator model: counts cycles with drive applied.
// Assumes drive and clear arrive on core_clk.
`default_nettype none
module hpwm_valve (
  // Clock
  input wire logic core_clk,
  // From the block
  input wire logic drive,
  input wire logic clear,
  // Observed on-time
  output logic [15:0] onCount
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge core_clk) begin
    if (clear)
      onCount <= {15'h0000, drive};
    else
      onCount <= onCount + {15'h0000, drive};
  end
endmodule // hpwm_valve
`default_nettype wire

//--- testbench/heating_pwm_cycle_tb.sv
// Bench: steady duty per period and mid-cycle changes.
// Assumes 2 cycles per tick, 100 ticks per period.
`default_nettype none
module heating_pwm_cycle_tb import hpwm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, resetn = 0, ctrlValid = 0;
  logic [PCT_W-1:0] ctrlPct = '0;
  logic actuatorOn, periodStart;
  logic [15:0] onCount;
  logic [31:0] lfsr = 32'hFD3A5078;
  int n_fail = 0, checks = 0;
  initial forever #5 core_clk = ~core_clk;
  hpwm_cycle #(.TICK_DIV(2), .PERIOD(100)) u_dut (.core_clk(core_clk), .resetn(resetn),
    .ctrlPct(ctrlPct), .ctrlValid(ctrlValid), .actuatorOn(actuatorOn),
    .periodStart(periodStart));
  hpwm_valve u_valve (.core_clk(core_clk), .drive(actuatorOn), .clear(periodStart),
    .onCount(onCount));
  ////////////////////////////////////////////////////////////////
  // Over-range clamps to full, one tick per percent
  function automatic logic [15:0] exp_on(input logic [PCT_W-1:0] p);
    return (p > PCT_FULL ? PCT_FULL : p) * 16'h0002;
  endfunction
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk) #1;
  endtask
  task automatic wait_start();
    int i;
    cyc(1);
    for (i = 0; i < 400 && periodStart !== 1'b1; i++) cyc(1);
  endtask
  task automatic set_pct(input logic [PCT_W-1:0] p);
    ctrlPct = p;
    ctrlValid = 1'b1;
    cyc(1);
    ctrlValid = 1'b0;
  endtask
  // Two boundaries so the counted period is a whole steady one
  task automatic steady(input logic [PCT_W-1:0] p);
    set_pct(p);
    wait_start();
    wait_start();
    chk("onCount", exp_on(p), onCount);
    $display("test steady %0d done", p);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    cyc(20);
    chk("resetOff", 16'h0000, {15'h0000, actuatorOn});
    resetn = 1'b1;
    steady(7'h00);
    steady(7'h64);
    steady(7'h7F);
    repeat (6) begin
      lfsr = lfsr_next(lfsr);
      steady(lfsr[6:0]);
    end
    steady(7'h14);
    cyc(60);
    set_pct(7'h32);
    cyc(1);
    chk("raiseOn", 16'h0001, {15'h0000, actuatorOn});
    wait_start();
    chk("raiseNext", exp_on(7'h32), onCount);
    cyc(40);
    set_pct(7'h1E);
    wait_start();
    chk("lowerCut", exp_on(7'h1E), onCount);
    set_pct(7'h50);
    cyc(100);
    set_pct(7'h14);
    cyc(1);
    chk("overrunOff", 16'h0000, {15'h0000, actuatorOn});
    wait_start();
    wait_start();
    chk("overrunNext", exp_on(7'h14), onCount);
    $display("test mid-cycle done");
    close_out();
  end
  initial begin
    #200000;
    n_fail++;
    close_out();
  end
endmodule // heating_pwm_cycle_tb
`default_nettype wire
